// file: verilog/cps_pkg.sv
// Purpose: constants for the control pin strap decoder
// Assumes: 125 MHz sys_clk_i, AHB-Lite register access
package cps_pkg;
	localparam int CLK_MHZ         = 125;
	localparam int SETTLE_NS       = 1000;
	localparam int SETTLE_CYC      = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W           = 8;

	// Trit codes, shared by equalizer, edge rate and termination fields
	typedef logic [1:0] cps_trit_t;
	localparam cps_trit_t TRIT_LOW   = 2'h0;
	localparam cps_trit_t TRIT_FLOAT = 2'h1;
	localparam cps_trit_t TRIT_HIGH  = 2'h2;

	// Edge rate: low slowest, float mid-range, high fastest
	localparam cps_trit_t EDGE_SLOW  = TRIT_LOW;
	localparam cps_trit_t EDGE_MID   = TRIT_FLOAT;
	localparam cps_trit_t EDGE_FAST  = TRIT_HIGH;
	// Termination: low 150-300 ohm, float none, high 75-150 ohm
	localparam cps_trit_t TERM_MID   = TRIT_LOW;
	localparam cps_trit_t TERM_NONE  = TRIT_FLOAT;
	localparam cps_trit_t TERM_STRONG = TRIT_HIGH;

	localparam int NUM_TRI         = 4;
	localparam int TRI_EQ1         = 0;
	localparam int TRI_EQ2         = 1;
	localparam int TRI_EDGE        = 2;
	localparam int TRI_TERM        = 3;

	// Register map, byte addresses
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CONFIG = 8'h08;

	// CTRL fields
	localparam int CTRL_RATIO   = 0;
	localparam int CTRL_DISPLAY = 1;
	localparam int CTRL_RESENSE = 2;
	localparam logic [2:0] CTRL_RESET = 3'h2;
	// CONFIG / STATUS field positions
	localparam int F_EMPH   = 0;
	localparam int F_SWAP   = 1;
	localparam int F_EQ1    = 2;
	localparam int F_EQ2    = 4;
	localparam int F_EDGE   = 6;
	localparam int F_TERM   = 8;
	localparam int CFG_W    = 10;
	localparam logic [9:0] CONFIG_RESET = 10'h050;
	localparam int ST_PDOWN = 16;
	localparam int ST_BUS   = 17;
	localparam int ST_VALID = 18;
	localparam int ST_ADDR  = 19;

	typedef enum logic [2:0] {
		SN_IDLE = 3'b001,
		SN_UP   = 3'b010,
		SN_DOWN = 3'b100
	} cps_sense_e;

	typedef enum logic [2:0] {
		MS_OFF   = 3'b001,
		MS_SENSE = 3'b010,
		MS_RUN   = 3'b100
	} cps_main_e;
endpackage : cps_pkg

// file: verilog/cps_tri_sense.sv
// Purpose: resolve one three-level strap pin by biasing it up then down
// Assumes: board strap of 1 kohm overrides the weak internal bias
// Notes: a floating pin follows the bias, a strapped one does not
`timescale 1ns/1ps
module cps_tri_sense
	import cps_pkg::*;
(
	// Clock and reset
	input  wire logic             sys_clk_i,
	input  wire logic             rst_n_i,
	// Control
	input  wire logic             start_i,
	input  wire logic             pin_i,
	// Results
	output logic                  pull_up_o,
	output logic                  done_o,
	output cps_pkg::cps_trit_t    level_o
);
	cps_sense_e           state_reg;
	logic [CNT_W-1:0]     cnt_reg;
	logic                 hi_seen_reg;
	logic                 settled;

	assign settled   = (cnt_reg == CNT_W'(SETTLE_CYC - 1));
	assign pull_up_o = (state_reg == SN_UP);

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_reg <= SN_IDLE;
			cnt_reg   <= '0;
		end else begin
			unique case (state_reg)
				SN_IDLE: begin
					cnt_reg <= '0;
					if (start_i) begin
						state_reg <= SN_UP;
					end
				end
				SN_UP: begin
					cnt_reg <= settled ? '0 : cnt_reg + 1'b1;
					if (settled) begin
						state_reg <= SN_DOWN;
					end
				end
				SN_DOWN: begin
					cnt_reg <= settled ? '0 : cnt_reg + 1'b1;
					if (settled) begin
						state_reg <= SN_IDLE;
					end
				end
				default: begin
					state_reg <= SN_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			hi_seen_reg <= 1'b0;
			level_o     <= TRIT_FLOAT;
			done_o      <= 1'b0;
		end else begin
			done_o <= (state_reg == SN_DOWN) && settled;
			if (state_reg == SN_UP && settled) begin
				hi_seen_reg <= pin_i;
			end
			if (state_reg == SN_DOWN && settled) begin
				if (hi_seen_reg && pin_i) begin
					level_o <= TRIT_HIGH;
				end else if (!hi_seen_reg && !pin_i) begin
					level_o <= TRIT_LOW;
				end else begin
					level_o <= TRIT_FLOAT;
				end
			end
		end
	end
endmodule : cps_tri_sense

// file: verilog/cps_strap_decoder.sv
// Purpose: decode enable, select and strap pins into operating configuration
// Assumes: pins synchronous to sys_clk_i; single AHB-Lite master
// Notes: zero-wait slave, always OKAY; unmapped reads return zero
//
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module cps_strap_decoder
	import cps_pkg::*;
(
	// Clock and reset
	input  wire logic                   sys_clk_i,
	input  wire logic                   rst_n_i,
	// AHB-Lite slave
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic [31:0]                 hrdata,
	output logic                        hreadyout,
	output logic                        hresp,
	// Mode pins
	input  wire logic                   enable_pin_i,
	input  wire logic                   select_pin_i,
	// Shared pins
	input  wire logic                   config_data_emphasis_pin_i,
	output logic                        config_data_emphasis_pin_o,
	output logic                        config_data_emphasis_pin_oe_n_o,
	input  wire logic                   config_clock_lane_pin_i,
	input  wire logic                   addr_lo_equalizer_pin_i,
	input  wire logic                   addr_hi_equalizer_pin_i,
	input  wire logic                   edge_rate_pin_i,
	input  wire logic                   term_pin_i,
	// Weak bias on three-level pins: 1 pull-up, 0 pull-down
	output logic [3:0]                  tri_pull_up_o,
	// Serial engine side
	input  wire logic                   ser_data_drive_low_i,
	output logic                        ser_data_o,
	output logic                        ser_clock_o,
	output logic [1:0]                  ser_addr_o,
	// Decoded configuration
	output logic                        power_down_o,
	output logic                        dev_reset_o,
	output logic                        bus_mode_o,
	output logic                        config_valid_o,
	output logic                        emphasis_level_o,
	output logic                        lane_swap_o,
	output cps_pkg::cps_trit_t          eq1_o,
	output cps_pkg::cps_trit_t          eq2_o,
	output cps_pkg::cps_trit_t          edge_rate_o,
	output cps_pkg::cps_trit_t          term_sel_o
);
	import cps_pkg::*;

	cps_main_e            state_reg;
	logic                 enable_prev_reg;
	logic                 enable_fall;
	logic [2:0]           ctrl_reg;
	logic [CFG_W-1:0]     config_reg;
	logic [CFG_W-1:0]     strap_reg;
	logic                 resense_reg;
	logic                 start_reg;
	logic [NUM_TRI-1:0]   tri_pin;
	logic [NUM_TRI-1:0]   tri_done;
	cps_trit_t            tri_level [NUM_TRI];
	logic [CFG_W-1:0]     active_cfg;
	logic                 wr_pend_reg;
	logic [7:0]           wr_addr_reg;
	logic                 ahb_go;
	logic [31:0]          status_word;
	logic [31:0]          rd_next;

	////////////////////////////////////////////////////////////////////////
	// Enable pin and reset handling

	assign enable_fall = enable_prev_reg && !enable_pin_i;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			enable_prev_reg <= 1'b0;
			dev_reset_o     <= 1'b0;
		end else begin
			enable_prev_reg <= enable_pin_i;
			dev_reset_o     <= enable_fall;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence: power-down, strap sensing, running

	// sense on leaving reset or power-down
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_reg <= MS_OFF;
			start_reg <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			unique case (state_reg)
				MS_OFF: begin
					if (enable_pin_i) begin
						state_reg <= MS_SENSE;
						start_reg <= 1'b1;
					end
				end
				MS_SENSE: begin
					if (!enable_pin_i) begin
						state_reg <= MS_OFF;
					end else if (&tri_done) begin
						state_reg <= MS_RUN;
					end
				end
				MS_RUN: begin
					if (!enable_pin_i) begin
						state_reg <= MS_OFF;
					end else if (resense_reg) begin
						state_reg <= MS_SENSE;
						start_reg <= 1'b1;
					end
				end
				default: begin
					state_reg <= MS_OFF;
				end
			endcase
		end
	end

	assign power_down_o   = (state_reg != MS_RUN);
	assign config_valid_o = (state_reg == MS_RUN);

	////////////////////////////////////////////////////////////////////////
	// Three-level pin sensing

	assign tri_pin[TRI_EQ1]  = addr_lo_equalizer_pin_i;
	assign tri_pin[TRI_EQ2]  = addr_hi_equalizer_pin_i;
	assign tri_pin[TRI_EDGE] = edge_rate_pin_i;
	assign tri_pin[TRI_TERM] = term_pin_i;

	// A sensor aborted by power-down simply reruns on the next start
	genvar gi;
	generate
		for (gi = 0; gi < NUM_TRI; gi++) begin : g_tri
			cps_tri_sense u_sense (
				.sys_clk_i (sys_clk_i),
				.rst_n_i   (rst_n_i && !enable_fall),
				.start_i   (start_reg),
				.pin_i     (tri_pin[gi]),
				.pull_up_o (tri_pull_up_o[gi]),
				.done_o    (tri_done[gi]),
				.level_o   (tri_level[gi])
			);
		end
	endgenerate

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || enable_fall) begin
			strap_reg <= CONFIG_RESET;
		end else if (state_reg == MS_SENSE && (&tri_done)) begin
			strap_reg[F_EMPH]      <= config_data_emphasis_pin_i;
			strap_reg[F_SWAP]      <= config_clock_lane_pin_i;
			strap_reg[F_EQ1 +: 2]  <= tri_level[TRI_EQ1];
			strap_reg[F_EQ2 +: 2]  <= tri_level[TRI_EQ2];
			strap_reg[F_EDGE +: 2] <= tri_level[TRI_EDGE];
			strap_reg[F_TERM +: 2] <= tri_level[TRI_TERM];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration select and outputs

	assign bus_mode_o = select_pin_i;
	assign active_cfg = select_pin_i ? config_reg : strap_reg;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || enable_fall) begin
			emphasis_level_o <= 1'b0;
			lane_swap_o      <= 1'b0;
			eq1_o            <= TRIT_FLOAT;
			eq2_o            <= TRIT_FLOAT;
			edge_rate_o      <= EDGE_MID;
			term_sel_o       <= TERM_NONE;
			ser_addr_o       <= 2'h0;
		end else begin
			// emphasis 0 dB or 3.5 dB
			emphasis_level_o <= active_cfg[F_EMPH];
			lane_swap_o      <= active_cfg[F_SWAP] && ctrl_reg[CTRL_DISPLAY];
			eq1_o            <= active_cfg[F_EQ1 +: 2];
			eq2_o            <= active_cfg[F_EQ2 +: 2];
			edge_rate_o      <= active_cfg[F_EDGE +: 2];
			if (ctrl_reg[CTRL_RATIO]) begin
				term_sel_o <= TERM_STRONG;
			end else begin
				term_sel_o <= active_cfg[F_TERM +: 2];
			end
			ser_addr_o <= {tri_level[TRI_EQ2] == TRIT_HIGH, tri_level[TRI_EQ1] == TRIT_HIGH};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared serial pins

	// data line is open-drain in bus mode
	// clock line passes through in bus mode
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			config_data_emphasis_pin_oe_n_o <= 1'b1;
			ser_data_o                      <= 1'b1;
			ser_clock_o                     <= 1'b1;
		end else begin
			config_data_emphasis_pin_oe_n_o <= !(select_pin_i && ser_data_drive_low_i
				&& enable_pin_i);
			ser_data_o  <= select_pin_i ? config_data_emphasis_pin_i : 1'b1;
			ser_clock_o <= select_pin_i ? config_clock_lane_pin_i : 1'b1;
		end
	end

	assign config_data_emphasis_pin_o = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign ahb_go    = hsel && htrans[1] && hready;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			wr_pend_reg <= ahb_go && hwrite;
			wr_addr_reg <= haddr[7:0];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || enable_fall) begin
			ctrl_reg    <= CTRL_RESET;
			config_reg  <= CONFIG_RESET;
			resense_reg <= 1'b0;
		end else begin
			resense_reg <= 1'b0;
			if (wr_pend_reg && wr_addr_reg == OFS_CTRL) begin
				ctrl_reg    <= {1'b0, hwdata[CTRL_DISPLAY], hwdata[CTRL_RATIO]};
				resense_reg <= hwdata[CTRL_RESENSE];
			end
			if (wr_pend_reg && wr_addr_reg == OFS_CONFIG) begin
				config_reg <= hwdata[CFG_W-1:0];
			end
		end
	end

	always_comb begin
		status_word                       = '0;
		status_word[F_EMPH]               = emphasis_level_o;
		status_word[F_SWAP]               = lane_swap_o;
		status_word[F_EQ1 +: 2]           = eq1_o;
		status_word[F_EQ2 +: 2]           = eq2_o;
		status_word[F_EDGE +: 2]          = edge_rate_o;
		status_word[F_TERM +: 2]          = term_sel_o;
		status_word[ST_PDOWN]             = power_down_o;
		status_word[ST_BUS]               = bus_mode_o;
		status_word[ST_VALID]             = config_valid_o;
		status_word[ST_ADDR +: 2]         = ser_addr_o;
	end

	always_comb begin
		rd_next = '0;
		if (haddr[7:0] == OFS_CTRL) begin
			rd_next = {29'h0, 1'b0, ctrl_reg[1:0]};
		end else if (haddr[7:0] == OFS_STATUS) begin
			rd_next = status_word;
		end else if (haddr[7:0] == OFS_CONFIG) begin
			rd_next = {22'h0, config_reg};
		end
		if (haddr[31:8] != 24'h0) begin
			rd_next = '0;
		end
	end

	// Read data registered at the address phase, so zero wait states
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			hrdata <= 32'h0;
		end else if (ahb_go && !hwrite) begin
			hrdata <= rd_next;
		end
	end
endmodule : cps_strap_decoder

// file: verification/cps_strap_checker.sv
// Purpose: port assertions for the strap decoder
// Assumes: one clock, sync active-low reset
// Notes: bound to every decoder instance
`timescale 1ns/1ps
module cps_strap_checker
	import cps_pkg::*;
(
	// Clock and reset
	input wire logic       sys_clk_i,
	input wire logic       rst_n_i,
	// Observed ports
	input wire logic       enable_pin_i,
	input wire logic       select_pin_i,
	input wire logic       config_data_emphasis_pin_i,
	input wire logic       config_data_emphasis_pin_oe_n_o,
	input wire logic       config_clock_lane_pin_i,
	input wire logic       ser_data_drive_low_i,
	input wire logic       ser_data_o,
	input wire logic       ser_clock_o,
	input wire logic       power_down_o,
	input wire logic       dev_reset_o,
	input wire logic       bus_mode_o,
	input wire logic       config_valid_o,
	input wire cps_trit_t  edge_rate_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////////
	property p_run_flags;
		power_down_o != config_valid_o;
	endproperty
	a_run_flags: assert property (p_run_flags) else $error("run flags disagree");
	property p_en_off;
		!enable_pin_i |=> power_down_o && !config_valid_o;
	endproperty
	a_en_off: assert property (p_en_off) else $error("no power-down");
	property p_rst_pulse;
		$fell(enable_pin_i) |-> ##[1:2] dev_reset_o;
	endproperty
	a_rst_pulse: assert property (p_rst_pulse) else $error("no reset pulse");
	property p_rst_once;
		dev_reset_o |=> !dev_reset_o;
	endproperty
	a_rst_once: assert property (p_rst_once) else $error("reset pulse too long");
	property p_bus_mode;
		bus_mode_o == select_pin_i;
	endproperty
	a_bus_mode: assert property (p_bus_mode) else $error("bus mode wrong");
	// Guarded by valid; ser_data_o and ser_clock_o still follow the pins in power-down
	property p_ser_data;
		select_pin_i && $past(select_pin_i) && config_valid_o && $past(config_valid_o)
			|-> ser_data_o == $past(config_data_emphasis_pin_i);
	endproperty
	a_ser_data: assert property (p_ser_data) else $error("serial data wrong");
	property p_ser_clk;
		select_pin_i && $past(select_pin_i) && config_valid_o && $past(config_valid_o)
			|-> ser_clock_o == $past(config_clock_lane_pin_i);
	endproperty
	a_ser_clk: assert property (p_ser_clk) else $error("serial clock wrong");
	property p_oe;
		!config_data_emphasis_pin_oe_n_o
			|-> $past(select_pin_i) && $past(enable_pin_i) && $past(ser_data_drive_low_i);
	endproperty
	a_oe: assert property (p_oe) else $error("data pin driven in strap mode");
	property p_hold;
		config_valid_o && $past(config_valid_o, 2) && !select_pin_i
			&& !$past(select_pin_i) && !$past(select_pin_i, 2) |-> $stable(edge_rate_o);
	endproperty
	a_hold: assert property (p_hold) else $error("strap value moved");
	c_run: cover property ($rose(config_valid_o));
	c_bus: cover property (config_valid_o && bus_mode_o);
	c_oe: cover property (!config_data_emphasis_pin_oe_n_o);
endmodule : cps_strap_checker

bind cps_strap_decoder cps_strap_checker i_cps_strap_checker (.sys_clk_i, .rst_n_i,
	.enable_pin_i, .select_pin_i, .config_data_emphasis_pin_i,
	.config_data_emphasis_pin_oe_n_o, .config_clock_lane_pin_i, .ser_data_drive_low_i,
	.ser_data_o, .ser_clock_o, .power_down_o, .dev_reset_o, .bus_mode_o,
	.config_valid_o, .edge_rate_o);

// file: verification/cps_strap_board.sv
// Purpose: board straps and open-drain data line
// Assumes: 1 kohm straps beat the weak internal bias
// Notes: two bits of strap code per three-level pin
`timescale 1ns/1ps
module cps_strap_board
	import cps_pkg::*;
(
	// From the decoder
	input  wire logic [3:0] tri_pull_up_i,
	input  wire logic       data_oe_n_i,
	// Board setup
	input  wire logic [7:0] tri_strap_i,
	input  wire logic       data_level_i,
	// Pin levels
	output logic [3:0]      tri_pin_o,
	output logic            data_pin_o
);
	// strap wins, open pin follows bias
	always_comb begin
		for (int i = 0; i < NUM_TRI; i++) begin
			case (tri_strap_i[2*i +: 2])
				TRIT_LOW:  tri_pin_o[i] = 1'b0;
				TRIT_HIGH: tri_pin_o[i] = 1'b1;
				default:   tri_pin_o[i] = tri_pull_up_i[i];
			endcase
		end
	end
	assign data_pin_o = data_oe_n_i ? data_level_i : 1'b0;
endmodule : cps_strap_board

// file: verification/tb_cps_strap_decoder.sv
// Purpose: directed bench for the strap decoder
// Assumes: zero-wait slave, one AHB-Lite master
// Notes: each strap sense takes about 253 cycles
`timescale 1ns/1ps
module tb_cps_strap_decoder;
	import cps_pkg::*;
	logic            sys_clk_i, rst_n_i, hsel, hwrite, enable_pin_i, select_pin_i;
	logic            lane_pin, drive_low, data_level, seen;
	logic [31:0]     haddr, hwdata, rd;
	logic [1:0]      htrans;
	logic [2:0]      hsize;
	logic [7:0]      straps;
	wire logic [31:0] hrdata;
	wire logic       hreadyout, hresp, oe_n, data_pin, pd, dev_rst, bus_mode, valid;
	wire logic       emph, swap, ser_data, ser_clk, pin_out;
	wire logic [3:0] tri_pull, tri_pin;
	wire logic [1:0] ser_addr;
	wire cps_trit_t  eq1, eq2, edge_rate, term;
	int              errors, samples_checked, cycles;

	cps_strap_decoder i_cps_strap_decoder (.sys_clk_i, .rst_n_i, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
		.enable_pin_i, .select_pin_i, .config_data_emphasis_pin_i(data_pin),
		.config_data_emphasis_pin_o(pin_out), .config_data_emphasis_pin_oe_n_o(oe_n),
		.config_clock_lane_pin_i(lane_pin), .addr_lo_equalizer_pin_i(tri_pin[0]),
		.addr_hi_equalizer_pin_i(tri_pin[1]), .edge_rate_pin_i(tri_pin[2]),
		.term_pin_i(tri_pin[3]), .tri_pull_up_o(tri_pull), .ser_data_drive_low_i(drive_low),
		.ser_data_o(ser_data), .ser_clock_o(ser_clk), .ser_addr_o(ser_addr),
		.power_down_o(pd), .dev_reset_o(dev_rst), .bus_mode_o(bus_mode),
		.config_valid_o(valid), .emphasis_level_o(emph), .lane_swap_o(swap),
		.eq1_o(eq1), .eq2_o(eq2), .edge_rate_o(edge_rate), .term_sel_o(term));
	cps_strap_board i_cps_strap_board (.tri_pull_up_i(tri_pull), .data_oe_n_i(oe_n),
		.tri_strap_i(straps), .data_level_i(data_level), .tri_pin_o(tri_pin),
		.data_pin_o(data_pin));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask : cyc
	// Entered just after a rising edge
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge sys_clk_i); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk_i); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic wait_valid();
		int n;
		n = 0;
		while (valid !== 1'b1 && n < 400) begin
			@(posedge sys_clk_i);
			n++;
		end
		chk(valid, 1'b1);
		cyc(2);
	endtask : wait_valid
	task automatic report_and_stop();
		if (errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	////////////////////////////////////////////////////////////////
	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 4000) begin
			errors++;
			report_and_stop();
		end
	end
	initial begin
		{rst_n_i, hsel, hwrite, enable_pin_i, select_pin_i, drive_low, data_level} = '0;
		{haddr, hwdata, htrans, errors, samples_checked, cycles} = '0;
		hsize = 3'h2;
		lane_pin = 1'b1;
		straps = 8'h55;
		cyc(6);
		rst_n_i <= 1'b1;
		cyc(1);
		chk(pd, 1'b1);
		bus(1'b0, 32'h8, 32'h0);
		chk(rd, 32'h50);
		bus(1'b0, 32'h0, 32'h0);
		chk(rd, 32'h2);
		bus(1'b1, 32'hc, 32'hffffffff);
		bus(1'b0, 32'hc, 32'h0);
		chk(rd, 32'h0);
		for (int k = 0; k < 3; k++) begin
			straps <= {2'(k), 2'((k + 2) % 3), 2'((k + 1) % 3), 2'(k)};
			data_level <= k[0];
			enable_pin_i <= 1'b1;
			cyc(1);
			wait_valid();
			chk(eq1, k);
			chk(eq2, (k + 1) % 3);
			chk(edge_rate, (k + 2) % 3);
			chk(term, k);
			chk(emph, k[0]);
			chk(swap, 1'b1);
			chk(pd, 1'b0);
			// Straps move after capture
			straps <= 8'haa;
			data_level <= ~k[0];
			cyc(3);
			chk(edge_rate, (k + 2) % 3);
			chk(emph, k[0]);
			enable_pin_i <= 1'b0;
			seen = 1'b0;
			repeat (3) begin
				@(posedge sys_clk_i);
				seen |= dev_rst;
			end
			chk(seen, 1'b1);
			// Outputs fall back to the reset configuration
			chk(term, CONFIG_RESET[F_TERM +: 2]);
			chk(pd, 1'b1);
		end
		straps <= 8'h00;
		enable_pin_i <= 1'b1;
		cyc(1);
		wait_valid();
		bus(1'b1, 32'h0, 32'h1);
		cyc(2);
		chk(term, TRIT_HIGH);
		chk(swap, 1'b0);
		bus(1'b1, 32'h0, 32'h2);
		cyc(2);
		chk(term, TRIT_LOW);
		chk(swap, 1'b1);
		// Re-sense on request picks up moved straps
		straps <= 8'h20;
		bus(1'b1, 32'h0, 32'h6);
		cyc(2);
		chk(valid, 1'b0);
		wait_valid();
		chk(edge_rate, TRIT_HIGH);
		chk(term, TRIT_LOW);
		enable_pin_i <= 1'b0;
		select_pin_i <= 1'b1;
		straps <= 8'h02;
		cyc(3);
		enable_pin_i <= 1'b1;
		cyc(1);
		wait_valid();
		bus(1'b1, 32'h8, 32'h185);
		cyc(2);
		chk({edge_rate, eq1, term, emph}, 7'h4b);
		chk(ser_addr, 2'h1);
		bus(1'b0, 32'h4, 32'h0);
		chk(rd, 32'h000e0185);
		chk({hreadyout, hresp}, 2'h2);
		lane_pin <= 1'b0;
		drive_low <= 1'b1;
		cyc(4);
		chk({bus_mode, oe_n, ser_data, ser_clk, pin_out}, 5'h10);
		drive_low <= 1'b0;
		cyc(3);
		chk(ser_data, 1'b1);
		report_and_stop();
	end
endmodule : tb_cps_strap_decoder
